// ==== hdl/arc_regs.sv ====
// Control and status registers of the digital audio receiver with its serial control port
`timescale 1ns/1ps
`include "arc_params.svh"

// Operation
// - Auto bit picks ratio per band, else manual
// - Base band: 512fs at 0, 256fs at 1
// - Double band: 256fs at 0, 512fs at 1
// - Demodulated master clock output inverted when bit set
// - Transition flag rests high, or low when set
// - Pin function: parallel inputs or selector inputs
// - External route passes pins 0-3 to outputs
// - Parallel mode ignores external route bit
// - Routed clock invert and routed data mute
// - Through output two: low or inputs 0-6
// - Switch wait 2.67, 1.33, 0.67 ms or none
// - Band indicator high only when locked in band
// - Writes at 0xE8 with command and chip address
// - Input present bits 0-6, bit 7 zero
// - Update flags set on event, clear after read
// - Error, non-PCM, emphasis report live status
// - Error follows content selection, always readable
// - Bits 16-19 detections, bits 20-23 zero
// - Pin levels in parallel mode at 0xEB
// - Rate code in bits 4-7 of 0xEB
// - Channel status 48 bits, preamble 16 bits
// - Read data leaves least significant bit first
module arc_regs #(
  parameter int WAIT0_CYC = `ARC_WAIT_CYC(`ARC_WAIT0_NS),
  parameter int WAIT1_CYC = `ARC_WAIT_CYC(`ARC_WAIT1_NS),
  parameter int WAIT2_CYC = `ARC_WAIT_CYC(`ARC_WAIT2_NS)
) (
  input  wire logic        clk_i,                  // System clock
  input  wire logic        reset_i,                // Synchronous reset
  input  wire logic        link_clk_i,             // Serial control clock
  input  wire logic        ce_i,                   // Frame enable from host
  input  wire logic        di_i,                   // Serial data from host
  output logic             dout_o,                 // Serial read data
  output logic             dout_oe_n_o,            // Read data drive enable
  input  wire logic [1:0]  chip_addr_i,            // Chip address straps
  input  wire logic [3:0]  gp_pin_i,               // General-purpose pins
  input  wire logic [6:0]  rx_in_i,                // Receiver inputs
  input  wire logic        demod_mck_i,            // Demodulated master clock
  input  wire logic        demod_bck_i,            // Demodulated bit clock
  input  wire logic        demod_lrck_i,           // Demodulated word clock
  input  wire logic        demod_data_i,           // Demodulated serial data
  input  wire logic        pll_locked_i,           // PLL lock identified
  input  wire logic        xfer_error_i,           // Transfer error
  input  wire logic        non_pcm_i,              // Non-PCM detected
  input  wire logic        emphasis_i,             // Pre-emphasis flagged
  input  wire logic        non_pcm_bit_i,          // Channel status bit 1
  input  wire logic        burst_found_i,          // Burst preamble found
  input  wire logic        sync_51_i,              // 5.1 sync word found
  input  wire logic        sync_61_i,              // 6.1 sync word found
  input  wire logic [6:0]  input_present_i,        // Per-input data present
  input  wire logic        input_monitor_enable_i, // Presence monitoring on
  input  wire logic        error_content_sel_i,    // Error includes non-PCM
  input  wire logic [3:0]  rate_code_i,            // Measured rate code
  input  wire logic        rate_update_i,          // Rate result updated
  input  wire logic [47:0] cs_bits_i,              // Channel status capture
  input  wire logic        cs_update_i,            // Channel status updated
  input  wire logic [15:0] pc_bits_i,              // Preamble Pc capture
  input  wire logic        pc_update_i,            // Preamble Pc updated
  input  wire logic        manual_ratio_512_i,     // Manual ratio, 1 = 512fs
  output logic             pll_ratio_512_o,        // PLL ratio, 1 = 512fs
  output logic             use_pll_clk_o,          // Clock switched to PLL
  output logic             clock_transition_flag_o,// Clock transition status
  output logic             rate_band_indicator_o,  // Rate within chosen band
  output logic             recv_master_clock_o,    // Master clock output
  output logic             recv_bit_clock_o,       // Bit clock output
  output logic             recv_word_clock_o,      // Word clock output
  output logic             recv_data_o,            // Serial data output
  output logic             through_output_two_o    // Second through output
);

  // Rate code inside an inclusive range
  function automatic logic in_range(input logic [3:0] code, input logic [3:0] lo,
                                    input logic [3:0] hi);
    in_range = (code >= lo) && (code <= hi);
  endfunction

  // ---------------- Pin synchronisers ----------------
  logic [13:0] pin_raw;                 // All asynchronous pins
  logic [13:0] s1_q, s2_q, s3_q;        // Three-stage chain
  logic [13:0] pin_q;                   // Filtered pin levels
  logic [13:0] pin_d;                   // Next filtered levels
  logic [3:0]  gp_f;                    // Filtered GP pins
  logic [6:0]  rx_f;                    // Filtered receiver inputs
  logic        ce_f;                    // Filtered frame enable
  logic [1:0]  chip_f;                  // Filtered chip address

  assign pin_raw = {chip_addr_i, ce_i, rx_in_i, gp_pin_i};
  // Change taken only once stages two and three agree
  assign pin_d   = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
  assign gp_f    = pin_q[3:0];
  assign rx_f    = pin_q[10:4];
  assign ce_f    = pin_q[11];
  assign chip_f  = pin_q[13:12];

  // Synchroniser chain and agreement filter
  always_ff @(posedge clk_i)
  begin
    s1_q  <= pin_raw;
    s2_q  <= s1_q;
    s3_q  <= s2_q;
    pin_q <= reset_i ? 14'h0000 : pin_d;
  end

  // ---------------- Link clock domain ----------------
  logic [7:0]  addr_sh_q;               // Device address, LSB first
  logic [15:0] data_sh_q;               // Written bits, LSB first
  logic [4:0]  bit_cnt_q;               // Bits shifted in this frame
  logic [5:0]  rd_idx_q;                // Next read bit position
  logic        dout_q;                  // Read data flop
  logic [47:0] rd_img;                  // Selected read register image
  logic        rd_bit;                  // Bit under the read pointer

  // Address while enable low, data while high
  always_ff @(posedge link_clk_i)
  begin
    if (!ce_i)
    begin
      addr_sh_q <= {di_i, addr_sh_q[7:1]};
      bit_cnt_q <= 5'h00;
    end
    else
    begin
      data_sh_q <= {di_i, data_sh_q[15:1]};
      bit_cnt_q <= (bit_cnt_q == 5'h1F) ? bit_cnt_q : bit_cnt_q + 5'h01;
    end
  end

  // Read data changes on falling edges, low bit first
  always_ff @(negedge link_clk_i)
  begin
    if (!ce_i)
    begin
      rd_idx_q <= 6'h00;
      dout_q   <= 1'b0;
    end
    else
    begin
      dout_q   <= rd_bit;
      rd_idx_q <= (rd_idx_q == 6'h2F) ? rd_idx_q : rd_idx_q + 6'h01;
    end
  end

  assign dout_o = dout_q;

  // ---------------- Read holding registers ----------------
  logic [23:0] hold_ea_q, ea_live;      // Detection and flags word
  logic [7:0]  hold_eb_q, eb_live;      // Pin levels and rate code
  logic [47:0] hold_ec_q;               // Channel status capture
  logic [15:0] hold_ed_q;               // Preamble Pc capture
  logic [4:0]  flag_q, flag_d;          // Sticky update flags
  logic [4:0]  flag_ev;                 // Flag events this cycle
  logic [4:0]  flag_held;               // Flags the host has seen
  logic [6:0]  present_dly_q;           // Previous presence bits
  logic [3:0]  gp_dly_q;                // Previous pin levels
  logic        error_status;            // Live error
  logic        ce_dly_q;                // Delayed frame enable
  logic        ce_fall;                 // Frame end in system domain
  logic        rd_clear;                // Detection word was read
  logic        rd_frame;                // Read frame open, EA to ED
  logic [7:0]  io2_q;                   // Data I/O setting 2

  // Held images are frozen while a frame is open, so link logic reads them quietly
  assign rd_img = (addr_sh_q == `ARC_RD_DETECT)   ? {24'h000000, hold_ea_q} :
                  (addr_sh_q == `ARC_RD_PINRATE)  ? {40'h0000000000, hold_eb_q} :
                  (addr_sh_q == `ARC_RD_CHSTAT)   ? hold_ec_q :
                  (addr_sh_q == `ARC_RD_PREAMBLE) ? {32'h00000000, hold_ed_q} :
                  48'h000000000000;
  assign rd_bit = rd_img[rd_idx_q];

  // Error follows unlock, transfer error and optional non-PCM
  assign error_status = ~pll_locked_i | xfer_error_i | (error_content_sel_i & non_pcm_i);

  // Flag events: input change, rate, status, preamble, pin update
  assign flag_ev[0] = input_monitor_enable_i & (input_present_i != present_dly_q);
  assign flag_ev[1] = rate_update_i;
  assign flag_ev[2] = cs_update_i;
  assign flag_ev[3] = pc_update_i;
  assign flag_ev[4] = ~io2_q[`ARC_IO_PIN_FUNC] & (gp_f != gp_dly_q);
  assign flag_held  = {hold_ea_q[14], hold_ea_q[13], hold_ea_q[11], hold_ea_q[10],
                       hold_ea_q[9]};
  assign ce_fall    = ce_dly_q & ~ce_f;
  assign rd_clear   = ce_fall & (addr_sh_q == `ARC_RD_DETECT);
  // Clear only what was reported; a new event wins over the clear
  assign flag_d     = (flag_q & ~(rd_clear ? flag_held : 5'h00)) | flag_ev;

  // Detection word layout
  assign ea_live = {4'h0, sync_61_i, sync_51_i, burst_found_i, non_pcm_bit_i,
                    emphasis_i, flag_q[4], flag_q[3], non_pcm_i, flag_q[2],
                    flag_q[1], flag_q[0], error_status, 1'b0, input_present_i};
  // Pin levels only in parallel mode, rate code above
  assign eb_live = {rate_code_i, io2_q[`ARC_IO_PIN_FUNC] ? 4'h0 : gp_f};

  // Sticky flags and edge history
  always_ff @(posedge clk_i)
  begin
    flag_q        <= reset_i ? 5'h00 : flag_d;
    present_dly_q <= reset_i ? 7'h00 : input_present_i;
    gp_dly_q      <= reset_i ? 4'h0 : gp_f;
    ce_dly_q      <= reset_i ? 1'b0 : ce_f;
  end

  // Holding images track live state between frames
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      hold_ea_q <= 24'h000000;
      hold_eb_q <= 8'h00;
      hold_ec_q <= 48'h000000000000;
      hold_ed_q <= 16'h0000;
    end
    else if (!ce_f)
    begin
      hold_ea_q <= ea_live;
      hold_eb_q <= eb_live;
      hold_ec_q <= cs_bits_i;
      hold_ed_q <= pc_bits_i;
    end
  end

  assign rd_frame = ce_f && (addr_sh_q >= `ARC_RD_DETECT) && (addr_sh_q <= `ARC_RD_PREAMBLE);
  // Drive enable low only while a read frame is open, never in a write
  always_ff @(posedge clk_i)
  begin
    dout_oe_n_o <= reset_i ? 1'b1 : ~rd_frame;
  end

  // ---------------- Write commands ----------------
  logic [7:0] set3_q;                   // System settings 3
  logic [7:0] pllclk_q;                 // PLL clock setting
  logic       wr_commit;                // Well-formed write ended
  logic [3:0] wr_cmd;                   // Command nibble
  logic [7:0] wr_data;                  // Second byte

  assign wr_cmd    = data_sh_q[7:4];
  assign wr_data   = data_sh_q[15:8];
  // Address, bit count, zero bits and chip address must all match
  assign wr_commit = ce_fall && (addr_sh_q == `ARC_WRITE_ADDR) &&
                     (bit_cnt_q == `ARC_WR_BITS) && (data_sh_q[3:2] == 2'b00) &&
                     (data_sh_q[1:0] == chip_f);

  // Settings registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      set3_q   <= `ARC_BYTE_RESET;
      io2_q    <= `ARC_BYTE_RESET;
      pllclk_q <= `ARC_BYTE_RESET;
    end
    else if (wr_commit)
    begin
      set3_q   <= (wr_cmd == `ARC_CMD_SET3)   ? wr_data : set3_q;
      io2_q    <= (wr_cmd == `ARC_CMD_IO2)    ? wr_data : io2_q;
      pllclk_q <= (wr_cmd == `ARC_CMD_PLLCLK) ? wr_data : pllclk_q;
    end
  end

  // ---------------- Ratio and band indicator ----------------
  logic       low_band;                 // 32, 44.1, 48 kHz
  logic       mid_band;                 // 88.2, 96 kHz
  logic       ratio_d;                  // Next ratio
  logic [1:0] band_sel;                 // Band choice
  logic       band_hit;                 // Rate inside chosen band

  assign low_band = in_range(rate_code_i, `ARC_FS_32K, `ARC_FS_48K);
  assign mid_band = in_range(rate_code_i, `ARC_FS_88K, `ARC_FS_96K);
  // Manual unless auto; then per-band selects
  assign ratio_d  = !set3_q[`ARC_S3_AUTO] ? manual_ratio_512_i :
                    low_band ? ~set3_q[`ARC_S3_LOW_SEL] :
                    mid_band ? set3_q[`ARC_S3_MID_SEL] : manual_ratio_512_i;
  assign band_sel = pllclk_q[`ARC_PC_BAND_LSB +: 2];
  // Band windows
  assign band_hit = (band_sel == 2'b00) ? in_range(rate_code_i, `ARC_FS_32K, `ARC_FS_48K) :
                    (band_sel == 2'b01) ? in_range(rate_code_i, `ARC_FS_64K, `ARC_FS_96K) :
                    (band_sel == 2'b10) ? in_range(rate_code_i, `ARC_FS_128K, `ARC_FS_192K) :
                    in_range(rate_code_i, `ARC_FS_64K, `ARC_FS_192K);

  // Ratio and indicator flops
  always_ff @(posedge clk_i)
  begin
    pll_ratio_512_o       <= reset_i ? 1'b0 : ratio_d;
    rate_band_indicator_o <= reset_i ? 1'b0 : (pll_locked_i & band_hit);
  end

  // ---------------- Clock switch wait ----------------
  arc_pkg::arc_sw_state_t sw_q, sw_d;   // Switch state
  arc_pkg::arc_wait_cnt_t wcnt_q;       // Remaining wait
  arc_pkg::arc_wait_cnt_t wait_load;    // Wait for current code
  logic [1:0]             wait_code;    // Wait selection

  assign wait_code = pllclk_q[`ARC_PC_WAIT_LSB +: 2];
  // Wait per code, none for code 3
  assign wait_load = (wait_code == 2'b00) ? arc_pkg::arc_wait_cnt_t'(WAIT0_CYC) :
                     (wait_code == 2'b01) ? arc_pkg::arc_wait_cnt_t'(WAIT1_CYC) :
                     (wait_code == 2'b10) ? arc_pkg::arc_wait_cnt_t'(WAIT2_CYC) :
                     17'h00000;

  // Next switch state; losing lock always falls back to the oscillator
  always_comb
  begin
    sw_d = sw_q;
    unique case (sw_q)
      arc_pkg::sw_osc:  sw_d = pll_locked_i ? arc_pkg::sw_wait : arc_pkg::sw_osc;
      arc_pkg::sw_wait: sw_d = !pll_locked_i ? arc_pkg::sw_osc :
                               (wcnt_q == 17'h00000) ? arc_pkg::sw_pll : arc_pkg::sw_wait;
      arc_pkg::sw_pll:  sw_d = pll_locked_i ? arc_pkg::sw_pll : arc_pkg::sw_osc;
      default:          sw_d = arc_pkg::sw_osc;
    endcase
  end

  // State, counter and switch outputs
  always_ff @(posedge clk_i)
  begin
    sw_q   <= reset_i ? arc_pkg::sw_osc : sw_d;
    wcnt_q <= reset_i ? 17'h00000 :
              (sw_q == arc_pkg::sw_osc) ? wait_load :
              (wcnt_q == 17'h00000) ? wcnt_q : wcnt_q - 17'h00001;
    use_pll_clk_o <= reset_i ? 1'b0 : (sw_d == arc_pkg::sw_pll);
    // Active during the wait; rest level per polarity
    clock_transition_flag_o <= reset_i ? 1'b1 :
                               (set3_q[`ARC_S3_CLOCK_TRANSITION_FLAG_POL] ~^ (sw_d == arc_pkg::sw_wait));
  end

  // ---------------- Audio output routing ----------------
  logic       route_ext;                // Pins drive the outputs
  logic [2:0] thru_sel;                 // Through output select
  logic       thru_d;                   // Next through output
  logic [7:0] thru_src;                 // Low level plus inputs

  // Route only in selector mode
  assign route_ext = io2_q[`ARC_IO_EXT_ROUTE] & io2_q[`ARC_IO_PIN_FUNC];
  assign thru_sel  = io2_q[`ARC_IO_THRU_LSB +: 3];
  assign thru_src  = {rx_f, 1'b0};
  assign thru_d    = thru_src[thru_sel];

  // Output flops
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      recv_master_clock_o  <= 1'b0;
      recv_bit_clock_o     <= 1'b0;
      recv_word_clock_o    <= 1'b0;
      recv_data_o          <= 1'b0;
      through_output_two_o <= 1'b0;
    end
    else
    begin
      recv_master_clock_o  <= route_ext ? (gp_f[0] ^ io2_q[`ARC_IO_CLK_INV]) :
                              (demod_mck_i ^ set3_q[`ARC_S3_MCK_INV]);
      recv_bit_clock_o     <= route_ext ? gp_f[1] : demod_bck_i;
      recv_word_clock_o    <= route_ext ? gp_f[2] : demod_lrck_i;
      recv_data_o          <= route_ext ? (gp_f[3] & ~io2_q[`ARC_IO_DATA_MUTE]) :
                              demod_data_i;
      through_output_two_o <= thru_d;
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  arc_pkg::arc_wait_cnt_t wlen_q;       // Cycles spent waiting
  arc_pkg::arc_wait_cnt_t wload_q;      // Wait loaded at entry

  // Wait length helper
  always_ff @(posedge clk_i)
  begin
    wlen_q  <= (sw_q == arc_pkg::sw_wait) ? wlen_q + 17'h00001 : 17'h00000;
    wload_q <= (sw_q == arc_pkg::sw_osc) ? wait_load : wload_q;
  end

  a_ratio_manual: assert property (!set3_q[`ARC_S3_AUTO] |=>
    pll_ratio_512_o == $past(manual_ratio_512_i)) else $error("manual ratio not followed");
  a_ratio_low_band: assert property (set3_q[`ARC_S3_AUTO] && low_band |=>
    pll_ratio_512_o != $past(set3_q[`ARC_S3_LOW_SEL])) else $error("low band ratio wrong");
  a_ratio_mid_band: assert property (set3_q[`ARC_S3_AUTO] && mid_band |=>
    pll_ratio_512_o == $past(set3_q[`ARC_S3_MID_SEL])) else $error("mid band ratio wrong");
  a_parallel_no_route: assert property (!io2_q[`ARC_IO_PIN_FUNC] |=>
    recv_bit_clock_o == $past(demod_bck_i)) else $error("parallel mode routed pins");
  a_routed_data_mute: assert property (route_ext && io2_q[`ARC_IO_DATA_MUTE] |=>
    !recv_data_o) else $error("routed data not muted");
  a_through_low: assert property (thru_sel == 3'b000 |=>
    !through_output_two_o) else $error("through output not low");
  a_wait_length: assert property (sw_q == arc_pkg::sw_wait &&
    sw_d == arc_pkg::sw_pll |-> wlen_q == wload_q) else $error("switch wait length wrong");
  a_band_unlocked: assert property (!pll_locked_i |=>
    !rate_band_indicator_o) else $error("indicator high while unlocked");
  a_flag_set_wins: assert property (rd_clear && flag_ev[1] |=>
    flag_q[1]) else $error("event lost on clear");
  a_flag_clears: assert property (rd_clear && flag_held[2] && !flag_ev[2] |=>
    !flag_q[2]) else $error("read flag not cleared");
  a_write_commit: assert property (wr_commit && wr_cmd == `ARC_CMD_IO2 |=>
    io2_q == $past(wr_data)) else $error("write not stored");

  c_route_ext: cover property (route_ext ##1 recv_master_clock_o);
  c_switch_pll: cover property (sw_q == arc_pkg::sw_wait ##1 sw_q == arc_pkg::sw_pll);
  c_read_clear: cover property (rd_clear && flag_held != 5'h00);

endmodule

// ==== hdl/arc_params.svh ====
// Offsets, field positions, codes and timing counts of the audio receiver register set
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH

// System clock rate in MHz
`define ARC_CLK_MHZ       40

// Device addresses on the serial control bus
`define ARC_WRITE_ADDR    8'hE8
`define ARC_RD_DETECT     8'hEA
`define ARC_RD_PINRATE    8'hEB
`define ARC_RD_CHSTAT     8'hEC
`define ARC_RD_PREAMBLE   8'hED

// Command codes in the upper nibble of the first written byte
`define ARC_CMD_SET3      4'hC
`define ARC_CMD_IO2       4'hD
`define ARC_CMD_PLLCLK    4'hE
`define ARC_CMD_BYTE_HI   4'hC
`define ARC_WR_BITS       5'h10
`define ARC_BYTE_RESET    8'h00

// System settings 3 field positions
`define ARC_S3_AUTO       0
`define ARC_S3_LOW_SEL    1
`define ARC_S3_MID_SEL    2
`define ARC_S3_MCK_INV    4
`define ARC_S3_CLOCK_TRANSITION_FLAG_POL   5

// Data I/O setting 2 field positions
`define ARC_IO_PIN_FUNC   0
`define ARC_IO_EXT_ROUTE  1
`define ARC_IO_CLK_INV    2
`define ARC_IO_DATA_MUTE  3
`define ARC_IO_THRU_LSB   4

// PLL clock field positions
`define ARC_PC_WAIT_LSB   2
`define ARC_PC_BAND_LSB   6

// Measured rate codes
`define ARC_FS_32K        4'h7
`define ARC_FS_48K        4'h9
`define ARC_FS_64K        4'hA
`define ARC_FS_88K        4'hB
`define ARC_FS_96K        4'hC
`define ARC_FS_128K       4'hD
`define ARC_FS_192K       4'hF

// Clock switch waits, in ns, and their cycle counts (every count rounds up)
`define ARC_WAIT0_NS      2670000
`define ARC_WAIT1_NS      1330000
`define ARC_WAIT2_NS      670000
`define ARC_WAIT_CYC(ns)  ((((ns) * `ARC_CLK_MHZ) + 999) / 1000)

`endif

// ==== hdl/arc_pkg.sv ====
// Types shared by the audio receiver register set
package arc_pkg;
  // Clock source switch states
  typedef enum logic [1:0] {sw_osc, sw_wait, sw_pll} arc_sw_state_t;
  // Switch wait counter
  typedef logic [16:0] arc_wait_cnt_t;
endpackage

// ==== dv/arc_host.sv ====
// Host model driving the serial control port
`timescale 1ns/1ps
module arc_host (
  output logic      lclk_o, // Link clock, still between frames
  output logic      ce_o,   // Frame enable
  output logic      di_o,   // Serial data to device
  input  wire logic dout_i  // Serial data from device
);
  initial {lclk_o, ce_o, di_o} = 3'h0;
  // One frame: address with ce low, then n data edges
  task automatic xfer(input logic [7:0] a, input logic [15:0] w, input int n,
                      output logic [47:0] r);
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      di_o = a[i]; // Address LSB first
      #32 lclk_o = 1'b1;
      #32 lclk_o = 1'b0;
    end
    #32 ce_o = 1'b1; // Enable moves off the link clock edges
    #224;
    for (int i = 0; i < n; i++)
    begin
      di_o = w[i % 16]; // Bits past 16 repeat the word
      #32 lclk_o = 1'b1;
      if (i > 0) r[i - 1] = dout_i; // LSB first
      #32 lclk_o = 1'b0;
    end
    #32 ce_o = 1'b0;
    di_o = ~di_o; // No stale level after release
    #256;
  endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the audio receiver register set
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, locked = 1'b0, mck = 1'b0;
  logic [1:0]  chip = 2'h1;
  logic [3:0]  gp = 4'h0, rate = 4'h0;
  logic [6:0]  rx = 7'h00;
  logic [15:0] st = 16'h0000; // Status lines
  logic [2:0]  upd = 3'h0;    // Update pulses
  logic        lclk, ce, di, dout, ratio, flag, band, mko, dto, thru, oe_n, pll, bco, wco;
  logic [47:0] r;
  int          err_total = 0, tests_run = 0, cyc = 0;
  arc_host arc_host_inst (.lclk_o(lclk), .ce_o(ce), .di_o(di), .dout_i(dout));
  arc_regs #(.WAIT0_CYC(20), .WAIT1_CYC(10), .WAIT2_CYC(5)) arc_regs_inst (
    .clk_i(clk), .reset_i(rst), .link_clk_i(lclk), .ce_i(ce), .di_i(di), .dout_o(dout),
    .dout_oe_n_o(oe_n), .chip_addr_i(chip), .gp_pin_i(gp), .rx_in_i(rx), .demod_mck_i(mck),
    .demod_bck_i(st[0]), .demod_lrck_i(st[1]), .demod_data_i(st[2]), .pll_locked_i(locked),
    .xfer_error_i(st[3]), .non_pcm_i(st[4]), .emphasis_i(st[5]), .non_pcm_bit_i(st[6]),
    .burst_found_i(st[7]), .sync_51_i(st[8]), .sync_61_i(st[9]), .input_present_i(st[6:0]),
    .input_monitor_enable_i(st[10]), .error_content_sel_i(st[11]), .rate_code_i(rate),
    .rate_update_i(upd[0]), .cs_bits_i({3{st}}), .cs_update_i(upd[1]), .pc_bits_i(st),
    .pc_update_i(upd[2]), .manual_ratio_512_i(st[12]), .pll_ratio_512_o(ratio),
    .use_pll_clk_o(pll), .clock_transition_flag_o(flag), .rate_band_indicator_o(band),
    .recv_master_clock_o(mko), .recv_bit_clock_o(bco), .recv_word_clock_o(wco),
    .recv_data_o(dto), .through_output_two_o(thru));
  initial forever #12.5 clk = ~clk;
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input string s, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // Write frame; the read data driver must stay off meanwhile
  task automatic wr(input logic [3:0] c, input logic [1:0] a, input logic [7:0] b);
    fork
      arc_host_inst.xfer(8'hE8, {b, c, 2'h0, a}, 16, r);
      begin
        repeat (30) @(posedge clk);
        chk("oe write", 1, oe_n);
      end
    join
    repeat (12) @(posedge clk);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_read();
    @(posedge clk) gp <= 4'hA;
    rate <= 4'hC;
    pause(8);
    chk("ratio", 1, ratio);
    fork
      arc_host_inst.xfer(8'hEB, 16'h0, 9, r);
      begin
        repeat (30) @(posedge clk);
        chk("oe read", 0, oe_n);
      end
    join
    chk("pins rate", 8'hCA, r[7:0]);
    arc_host_inst.xfer(8'hED, 16'h0, 17, r);
    chk("pc", st, r[15:0]);
    arc_host_inst.xfer(8'hEC, 16'h0, 49, r);
    chk("cs", {3{st}}, r);
    @(posedge clk) upd <= 3'h7;
    @(posedge clk) upd <= 3'h0;
    arc_host_inst.xfer(8'hEA, 16'h0, 25, r);
    chk("cs flag", 1, r[11]);
    chk("flags", 8'h7F, r[15:8]);
    chk("detect", {1'b0, st[6:0]}, r[7:0]);
    chk("sync", 4'h1, r[19:16]);
    chk("top", 0, r[23:20]);
    arc_host_inst.xfer(8'hEA, 16'h0, 25, r);
    chk("cs flag clr", 0, r[11]);
    chk("flags clr", 8'h11, r[15:8]);
    $display("test read done");
  endtask
  task automatic t_thru();
    for (int c = 0; c < 8; c++)
    begin
      wr(4'hD, chip, 8'(c << 4));
      for (int p = 0; p < 2; p++)
      begin
        @(posedge clk) rx <= p ? 7'h55 : 7'h2A;
        pause(8);
        chk("thru", c ? rx[c - 1] : 1'b0, thru);
      end
    end
    wr(4'hD, ~chip, 8'h00);
    chk("thru kept", 1, thru);
    $display("test thru done");
  endtask
  task automatic t_route();
    wr(4'hC, chip, 8'h30);
    @(posedge clk) mck <= 1'b1;
    gp <= 4'hA;
    pause(8);
    chk("mck", 0, mko);
    chk("flag", 0, flag);
    wr(4'hD, chip, 8'h02);
    chk("data", st[2], dto);
    chk("word", st[1], wco);
    wr(4'hD, chip, 8'h03);
    chk("data", 1, dto);
    chk("bit clk", 1, bco);
    chk("word", 0, wco);
    chk("mck", 0, mko);
    wr(4'hD, chip, 8'h0F);
    chk("data", 0, dto);
    chk("mck", 1, mko);
    $display("test route done");
  endtask
  task automatic t_band();
    @(posedge clk) locked <= 1'b1;
    pause(5);
    chk("wait flag", 1, flag);
    chk("pll early", 0, pll);
    wr(4'hC, chip, 8'h01);
    chk("pll", 1, pll);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2) wr(4'hC, chip, 8'h07);
      @(posedge clk) rate <= i[0] ? 4'hC : 4'h9;
      pause(4);
      chk("ratio", i == 0 || i == 3, ratio);
    end
    chk("band", 0, band);
    wr(4'hE, chip, 8'h40);
    chk("band", 1, band);
    @(posedge clk) locked <= 1'b0;
    pause(4);
    chk("band", 0, band);
    chk("pll off", 0, pll);
    $display("test band done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    pause(3);
    rst <= 1'b0;
    pause(4);
    chk("flag", 1, flag);
    chk("thru", 0, thru);
    chk("oe idle", 1, oe_n);
    @(posedge clk) st <= 16'h1C5A;
    t_read();
    t_thru();
    t_route();
    t_band();
    tally_and_finish();
  end
endmodule
